// file: verilog/lithium_charge_controller.sv
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ns
// Behaviour
// - Start only with battery and supply present
// - Qualify picks suspend, complete, precharge or current regulation
// - Suspend stops charge when conditions fail
// - Precharge uses configurable low target current
// - Current regulation holds target, limits voltage
// - Target voltage reached moves to voltage regulation
// - Voltage regulation ends at taper current
// - Taper threshold differs by charge temperature
// - Separate time limits per charging state
// - Recharge restarts at configured recharge voltage
// - Temperature checked against start and charge limits
// - Voltage checked against start limits, target
// - Charge PWM to buck, up to 1 MHz
// - Second PWM duty sets current level
// - Two status LEDs, configurable flash rates
// - Measurements come from 10-bit converter
// - Parameters held in 256-byte store
// - Runs from own clock, no external source
// - Reset always enters charge pending
// - Battery removal returns to charge pending
// - Qualify: bad temperature suspends, low voltage precharges
module lithium_charge_controller #(
  parameter int SEC_CYCLES = charge_pkg::SEC_CYCLES,
  parameter int MS_CYCLES = charge_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Presence pins
  input wire logic battery_present_i,
  input wire logic supply_ok_i,
  // Converter handshake
  output charge_pkg::adc_chan_t adc_chan_o,
  output logic adc_start_o,
  input wire logic adc_done_i,
  input wire logic [charge_pkg::ADC_BITS-1:0] adc_result_i,
  // Drive outputs
  output logic charge_pwm_out_o,
  output logic current_level_pwm_out_o,
  output logic status_led_a_o,
  output logic status_led_b_o
);
  import charge_pkg::*;

  logic [7:0] store_mem [PARAM_BYTES];
  logic [31:0] ctrl_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [2:0] bp_sync_q;
  logic [2:0] sup_sync_q;
  logic battery_present_q;
  logic supply_ok_q;
  adc_chan_t chan_q;
  logic conv_busy_q;
  logic start_q;
  logic scan_done_q;
  logic meas_valid_q;
  logic [ADC_BITS-1:0] volt_q;
  logic [ADC_BITS-1:0] curr_q;
  logic [ADC_BITS-1:0] temp_q;
  charge_state_t state_q;
  charge_state_t state_d;
  logic [31:0] sec_div_q;
  logic [15:0] state_secs_q;
  logic [15:0] duty_q;
  logic [31:0] ms_div_q;
  logic [15:0] fast_cnt_q;
  logic [15:0] slow_cnt_q;
  logic fast_ph_q;
  logic slow_ph_q;
  logic led_a_q;
  logic led_b_q;
  logic apb_acc;
  logic apb_wr;
  logic store_hit;
  logic start_temp_ok;
  logic [ADC_BITS-1:0] taper_lvl;
  logic [15:0] pwm_period;
  logic charging;

  function automatic logic [15:0] prm16(input logic [7:0] idx);
    prm16 = {store_mem[idx + 8'h01], store_mem[idx]};
  endfunction

  function automatic logic [ADC_BITS-1:0] lvl(input logic [7:0] idx);
    logic [15:0] v;
    v = prm16(idx);
    lvl = v[ADC_BITS-1:0];
  endfunction

  function automatic logic [15:0] half_ms(input logic [7:0] idx);
    logic [15:0] v;
    v = prm16(idx);
    half_ms = (v == 16'h0000) ? 16'h0001 : v;
  endfunction

  // APB: one wait state so read data comes from a flop
  assign apb_acc = psel_i && penable_i && !pready_q;
  assign apb_wr = psel_i && penable_i && pready_q && pwrite_i && !pslverr_q;
  assign store_hit = (paddr_i <= ADDR_STORE_LAST);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= apb_acc;
      pslverr_q <= apb_acc && !store_hit && paddr_i != ADDR_CTRL && paddr_i != ADDR_STATUS
                   && paddr_i != ADDR_MEAS_VI && paddr_i != ADDR_MEAS_TD;
      if (apb_acc && !pwrite_i) begin
        if (store_hit) begin
          prdata_q <= {24'h00_0000, store_mem[paddr_i[9:2]]};
        end else begin
          case (paddr_i)
            ADDR_CTRL: prdata_q <= ctrl_q;
            ADDR_STATUS: prdata_q <= {26'h000_0000, meas_valid_q, supply_ok_q, battery_present_q, state_q};
            ADDR_MEAS_VI: prdata_q <= {6'h00, curr_q, 6'h00, volt_q};
            ADDR_MEAS_TD: prdata_q <= {duty_q, 6'h00, temp_q};
            default: prdata_q <= 32'h0000_0000;
          endcase
        end
      end else if (apb_acc) begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // Nonvolatile store: no reset, contents survive reset
  always_ff @(posedge sys_clk_i) begin
    if (apb_wr && store_hit) begin
      store_mem[paddr_i[9:2]] <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (apb_wr && paddr_i == ADDR_CTRL) begin
      ctrl_q <= {31'h0000_0000, pwdata_i[CTRL_ENABLE_BIT]};
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;

  // Pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bp_sync_q <= 3'h0;
      sup_sync_q <= 3'h0;
      battery_present_q <= 1'b0;
      supply_ok_q <= 1'b0;
    end else begin
      bp_sync_q <= {bp_sync_q[1:0], battery_present_i};
      sup_sync_q <= {sup_sync_q[1:0], supply_ok_i};
      if (bp_sync_q[1] == bp_sync_q[2]) begin
        battery_present_q <= bp_sync_q[2];
      end
      if (sup_sync_q[1] == sup_sync_q[2]) begin
        supply_ok_q <= sup_sync_q[2];
      end
    end
  end

  // Converter scan: voltage, current, temperature in turn
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      chan_q <= CH_VOLT;
      conv_busy_q <= 1'b0;
      start_q <= 1'b0;
      scan_done_q <= 1'b0;
      meas_valid_q <= 1'b0;
      volt_q <= '0;
      curr_q <= '0;
      temp_q <= '0;
    end else begin
      start_q <= !conv_busy_q;
      scan_done_q <= 1'b0;
      if (!conv_busy_q) begin
        conv_busy_q <= 1'b1;
      end else if (adc_done_i) begin
        conv_busy_q <= 1'b0;
        case (chan_q)
          CH_VOLT: begin
            volt_q <= adc_result_i;
            chan_q <= CH_CURR;
          end
          CH_CURR: begin
            curr_q <= adc_result_i;
            chan_q <= CH_TEMP;
          end
          default: begin
            temp_q <= adc_result_i;
            chan_q <= CH_VOLT;
            scan_done_q <= 1'b1;
            meas_valid_q <= 1'b1;
          end
        endcase
      end
    end
  end

  assign adc_chan_o = chan_q;
  assign adc_start_o = start_q;

  // Limit checks
  assign start_temp_ok = temp_q >= lvl(P_MIN_START_TEMP) && temp_q <= lvl(P_MAX_START_TEMP);
  assign taper_lvl = (temp_q < lvl(P_TAPER_SPLIT_TEMP)) ? lvl(P_TAPER_COLD) : lvl(P_TAPER_WARM);

  // Charge sequencer; measurement checks only on a fresh measurement set, pin, enable and time-limit moves on any cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_PENDING: begin
        if (battery_present_q && supply_ok_q && ctrl_q[CTRL_ENABLE_BIT]) begin
          state_d = ST_QUALIFY;
        end
      end
      ST_QUALIFY: begin
        if (scan_done_q) begin
          if (!start_temp_ok) begin
            state_d = ST_SUSPEND;
          end else if (volt_q > lvl(P_RECHARGE_VOLT)) begin
            state_d = ST_COMPLETE;
          end else if (volt_q < lvl(P_MIN_START_VOLT)) begin
            state_d = ST_PRECHARGE;
          end else begin
            state_d = ST_CURREG;
          end
        end
      end
      ST_SUSPEND: begin
        if (scan_done_q && start_temp_ok && volt_q < lvl(P_RECHARGE_VOLT)) begin
          state_d = ST_PRECHARGE;
        end
      end
      ST_PRECHARGE: begin
        if (scan_done_q && start_temp_ok && volt_q > lvl(P_MIN_START_VOLT)) begin
          state_d = ST_CURREG;
        end else if (state_secs_q >= prm16(P_PRECHG_LIMIT_S)) begin
          state_d = ST_SUSPEND;
        end
      end
      ST_CURREG: begin
        if (scan_done_q && (volt_q > lvl(P_MAX_START_VOLT) || !start_temp_ok)) begin
          state_d = ST_SUSPEND;
        end else if (scan_done_q && volt_q >= lvl(P_TARGET_VOLT) && temp_q < lvl(P_MAX_CHG_TEMP)) begin
          state_d = ST_VOLTREG;
        end else if (state_secs_q >= prm16(P_CURREG_LIMIT_S)) begin
          state_d = ST_SUSPEND;
        end
      end
      ST_VOLTREG: begin
        if (scan_done_q && temp_q > lvl(P_MAX_CHG_TEMP)) begin
          state_d = ST_SUSPEND;
        end else if (scan_done_q && curr_q <= taper_lvl) begin
          state_d = ST_COMPLETE;
        end else if (state_secs_q >= prm16(P_VOLTREG_LIMIT_S)) begin
          state_d = ST_COMPLETE;
        end
      end
      ST_COMPLETE: begin
        if (scan_done_q && volt_q <= lvl(P_RECHARGE_VOLT)) begin
          state_d = ST_QUALIFY;
        end
      end
      default: state_d = ST_PENDING;
    endcase
    // Pack removal or supply loss overrides everything
    if (state_q != ST_PENDING && (!battery_present_q || !supply_ok_q || !ctrl_q[CTRL_ENABLE_BIT])) begin
      state_d = ST_PENDING;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= ST_PENDING;
    end else begin
      state_q <= state_d;
    end
  end

  // Seconds in current state, restarted on every change
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || state_d != state_q) begin
      sec_div_q <= 32'h0000_0000;
      state_secs_q <= 16'h0000;
    end else if (sec_div_q >= 32'(SEC_CYCLES - 1)) begin
      sec_div_q <= 32'h0000_0000;
      if (state_secs_q != 16'hFFFF) begin
        state_secs_q <= state_secs_q + 16'h0001;
      end
    end else begin
      sec_div_q <= sec_div_q + 32'h0000_0001;
    end
  end

  // Duty steps one count per scan; slow loop, but cannot overshoot hard
  assign charging = (state_q == ST_PRECHARGE) || (state_q == ST_CURREG) || (state_q == ST_VOLTREG);
  assign pwm_period = (prm16(P_PWM_PERIOD) < MIN_PWM_PERIOD) ? MIN_PWM_PERIOD : prm16(P_PWM_PERIOD);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !charging) begin
      duty_q <= 16'h0000;
    end else if (scan_done_q) begin
      if (state_q == ST_VOLTREG) begin
        if (volt_q < lvl(P_TARGET_VOLT) && duty_q < pwm_period) begin
          duty_q <= duty_q + 16'h0001;
        end else if (volt_q > lvl(P_TARGET_VOLT) && duty_q != 16'h0000) begin
          duty_q <= duty_q - 16'h0001;
        end
      end else if (volt_q < lvl(P_TARGET_VOLT) && duty_q < pwm_period
                   && curr_q < ((state_q == ST_PRECHARGE) ? lvl(P_PRECHG_CURR) : lvl(P_TARGET_CURR))) begin
        duty_q <= duty_q + 16'h0001;
      end else if (duty_q != 16'h0000) begin
        duty_q <= duty_q - 16'h0001;
      end
    end
  end

  pwm_if chg_pwm ();
  pwm_if lvl_pwm ();

  assign chg_pwm.enable = charging;
  assign chg_pwm.period = pwm_period;
  assign chg_pwm.duty = duty_q;
  assign lvl_pwm.enable = charging;
  assign lvl_pwm.period = CTRL_PWM_PERIOD;
  assign lvl_pwm.duty = {6'h00, (state_q == ST_PRECHARGE) ? lvl(P_PRECHG_CURR) : lvl(P_TARGET_CURR)};

  pwm_gen u_chg_pwm (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pwm(chg_pwm)
  );

  pwm_gen u_lvl_pwm (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pwm(lvl_pwm)
  );

  assign charge_pwm_out_o = chg_pwm.pwm_out;
  assign current_level_pwm_out_o = lvl_pwm.pwm_out;

  // LED flash phases from millisecond tick
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ms_div_q <= 32'h0000_0000;
      fast_cnt_q <= 16'h0000;
      slow_cnt_q <= 16'h0000;
      fast_ph_q <= 1'b0;
      slow_ph_q <= 1'b0;
    end else if (ms_div_q >= 32'(MS_CYCLES - 1)) begin
      ms_div_q <= 32'h0000_0000;
      if (fast_cnt_q + 16'h0001 >= half_ms(P_LED_FAST_MS)) begin
        fast_cnt_q <= 16'h0000;
        fast_ph_q <= !fast_ph_q;
      end else begin
        fast_cnt_q <= fast_cnt_q + 16'h0001;
      end
      if (slow_cnt_q + 16'h0001 >= half_ms(P_LED_SLOW_MS)) begin
        slow_cnt_q <= 16'h0000;
        slow_ph_q <= !slow_ph_q;
      end else begin
        slow_cnt_q <= slow_cnt_q + 16'h0001;
      end
    end else begin
      ms_div_q <= ms_div_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      led_a_q <= 1'b0;
      led_b_q <= 1'b0;
    end else begin
      case (state_q)
        ST_QUALIFY: begin
          led_a_q <= slow_ph_q;
          led_b_q <= 1'b0;
        end
        ST_SUSPEND: begin
          led_a_q <= 1'b0;
          led_b_q <= fast_ph_q;
        end
        ST_PRECHARGE: begin
          led_a_q <= fast_ph_q;
          led_b_q <= 1'b0;
        end
        ST_CURREG: begin
          led_a_q <= 1'b1;
          led_b_q <= 1'b0;
        end
        ST_VOLTREG: begin
          led_a_q <= 1'b1;
          led_b_q <= slow_ph_q;
        end
        ST_COMPLETE: begin
          led_a_q <= 1'b0;
          led_b_q <= 1'b1;
        end
        default: begin
          led_a_q <= 1'b0;
          led_b_q <= 1'b0;
        end
      endcase
    end
  end

  assign status_led_a_o = led_a_q;
  assign status_led_b_o = led_b_q;

  // Logic runs on sys_clk_i alone; no external oscillator needed
endmodule

// file: verilog/charge_pkg.sv
package charge_pkg;

  // Clock and time bases
  localparam int CLK_HZ = 10_000_000;
  localparam int SEC_PERIOD_S = 1;
  localparam int SEC_CYCLES = SEC_PERIOD_S * CLK_HZ;
  localparam int MS_PERIOD_MS = 1;
  localparam int MS_CYCLES = (MS_PERIOD_MS * CLK_HZ) / 1000;
  localparam int MAX_PWM_HZ = 1_000_000;
  localparam logic [15:0] MIN_PWM_PERIOD = 16'(CLK_HZ / MAX_PWM_HZ);
  localparam logic [15:0] CTRL_PWM_PERIOD = 16'h0400;

  // Sizes
  localparam int ADC_BITS = 10;
  localparam int PARAM_BYTES = 256;

  // Parameter store layout: byte index of each 16-bit little-endian value
  localparam logic [7:0] P_MIN_START_TEMP = 8'h00;
  localparam logic [7:0] P_MAX_START_TEMP = 8'h02;
  localparam logic [7:0] P_MAX_CHG_TEMP = 8'h04;
  localparam logic [7:0] P_MIN_START_VOLT = 8'h06;
  localparam logic [7:0] P_MAX_START_VOLT = 8'h08;
  localparam logic [7:0] P_TARGET_VOLT = 8'h0A;
  localparam logic [7:0] P_RECHARGE_VOLT = 8'h0C;
  localparam logic [7:0] P_TARGET_CURR = 8'h0E;
  localparam logic [7:0] P_PRECHG_CURR = 8'h10;
  localparam logic [7:0] P_TAPER_COLD = 8'h12;
  localparam logic [7:0] P_TAPER_WARM = 8'h14;
  localparam logic [7:0] P_TAPER_SPLIT_TEMP = 8'h16;
  localparam logic [7:0] P_PRECHG_LIMIT_S = 8'h18;
  localparam logic [7:0] P_CURREG_LIMIT_S = 8'h1A;
  localparam logic [7:0] P_VOLTREG_LIMIT_S = 8'h1C;
  localparam logic [7:0] P_PWM_PERIOD = 8'h1E;
  localparam logic [7:0] P_LED_FAST_MS = 8'h20;
  localparam logic [7:0] P_LED_SLOW_MS = 8'h22;

  // APB map
  localparam logic [11:0] ADDR_STORE_LAST = 12'h3FC;
  localparam logic [11:0] ADDR_CTRL = 12'h400;
  localparam logic [11:0] ADDR_STATUS = 12'h404;
  localparam logic [11:0] ADDR_MEAS_VI = 12'h408;
  localparam logic [11:0] ADDR_MEAS_TD = 12'h40C;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_ENABLE_BIT = 0;

  typedef enum logic [2:0] {
    ST_PENDING   = 3'b000,
    ST_QUALIFY   = 3'b001,
    ST_SUSPEND   = 3'b010,
    ST_PRECHARGE = 3'b011,
    ST_CURREG    = 3'b100,
    ST_VOLTREG   = 3'b101,
    ST_COMPLETE  = 3'b110
  } charge_state_t;

  typedef enum logic [1:0] {
    CH_VOLT = 2'b00,
    CH_CURR = 2'b01,
    CH_TEMP = 2'b10
  } adc_chan_t;

endpackage

// file: verilog/pwm_if.sv
`timescale 1ns/1ns
interface pwm_if;
  logic enable;
  logic [15:0] period;
  logic [15:0] duty;
  logic pwm_out;
  modport ctrl (output enable, output period, output duty, input pwm_out);
  modport gen (input enable, input period, input duty, output pwm_out);
endinterface

// file: verilog/pwm_gen.sv
`timescale 1ns/1ns
module pwm_gen (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Settings and output
  pwm_if.gen pwm
);
  import charge_pkg::*;

  logic [15:0] cnt_q;
  logic [15:0] duty_q;
  logic out_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !pwm.enable || cnt_q >= pwm.period - 16'h0001) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Duty taken only at period start; a mid-period raise would add an extra edge
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      duty_q <= 16'h0000;
    end else if (!pwm.enable || cnt_q >= pwm.period - 16'h0001) begin
      duty_q <= pwm.duty;
    end
  end

  // Registered so the pin never glitches on a duty update
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      out_q <= 1'b0;
    end else begin
      out_q <= pwm.enable && (cnt_q < duty_q);
    end
  end

  assign pwm.pwm_out = out_q;
endmodule

// file: verification/adc_model.sv
`timescale 1ns/1ns
module adc_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Converter handshake
  input wire charge_pkg::adc_chan_t adc_chan_i,
  input wire logic adc_start_i,
  output logic adc_done_o,
  output logic [charge_pkg::ADC_BITS-1:0] adc_result_o,
  // Analog levels seen by the converter
  input wire logic [charge_pkg::ADC_BITS-1:0] volt_i,
  input wire logic [charge_pkg::ADC_BITS-1:0] curr_i,
  input wire logic [charge_pkg::ADC_BITS-1:0] temp_i
);
  import charge_pkg::*;
  logic busy_q;
  logic slow_q;
  logic [2:0] cnt_q;
  adc_chan_t chan_q;
  // Alternates prompt and slow answers; result line churns outside done
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      slow_q <= 1'b0;
      cnt_q <= 3'h0;
      chan_q <= CH_VOLT;
      adc_done_o <= 1'b0;
      adc_result_o <= 10'h2AA;
    end else begin
      adc_done_o <= 1'b0;
      adc_result_o <= ~adc_result_o;
      if (adc_start_i) begin
        busy_q <= 1'b1;
        chan_q <= adc_chan_i;
        cnt_q <= slow_q ? 3'h4 : 3'h0;
        slow_q <= !slow_q;
      end else if (busy_q && cnt_q != 3'h0) begin
        cnt_q <= cnt_q - 3'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        adc_done_o <= 1'b1;
        adc_result_o <= (chan_q == CH_VOLT) ? volt_i : (chan_q == CH_CURR) ? curr_i : temp_i;
      end
    end
  end
endmodule

// file: verification/charge_props.sv
`timescale 1ns/1ns
module charge_props (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Pins and converter
  input wire logic battery_present_i,
  input wire logic supply_ok_i,
  input wire charge_pkg::adc_chan_t adc_chan_o,
  input wire logic adc_start_o,
  input wire logic adc_done_i,
  // Drives
  input wire logic charge_pwm_out_o,
  input wire logic current_level_pwm_out_o,
  input wire logic status_led_a_o,
  input wire logic status_led_b_o
);
  import charge_pkg::*;
  logic wait_q;
  adc_chan_t chan_q;
  adc_chan_t nxt;
  assign nxt = (chan_q == CH_TEMP) ? CH_VOLT : adc_chan_t'(chan_q + 2'b01);
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wait_q <= 1'b0;
      chan_q <= CH_VOLT;
    end else if (adc_start_o) begin
      wait_q <= 1'b1;
      chan_q <= adc_chan_o;
    end else if (adc_done_i) begin
      wait_q <= 1'b0;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence access_s; psel_i && penable_i && !pready_o; endsequence
  sequence answer_s; pready_o ##1 !pready_o; endsequence
  apb_one_wait_a: assert property (access_s |=> answer_s) else $error("bus answer late or long");
  err_with_ready_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  start_pulse_a: assert property (adc_start_o |=> !adc_start_o) else $error("start not a pulse");
  chan_hold_a: assert property (wait_q |-> adc_chan_o == chan_q) else $error("channel moved");
  scan_order_a: assert property (wait_q && adc_done_i |-> ##2 (adc_start_o && adc_chan_o == $past(nxt, 2)))
    else $error("scan order broken");
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !adc_start_o && !pready_o &&
    !charge_pwm_out_o && !current_level_pwm_out_o && !status_led_a_o && !status_led_b_o) else $error("reset not quiet");
  pack_gone_a: assert property (!battery_present_i [*8] |-> !charge_pwm_out_o &&
    !current_level_pwm_out_o && !status_led_a_o && !status_led_b_o) else $error("drive without pack");
  no_supply_a: assert property (!supply_ok_i [*8] |-> !charge_pwm_out_o) else $error("drive without supply");
  pwm_rate_a: assert property ($rose(charge_pwm_out_o) |=> (!$rose(charge_pwm_out_o)) [*8])
    else $error("charge pwm too fast");
endmodule

bind lithium_charge_controller charge_props u_props (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .battery_present_i(battery_present_i), .supply_ok_i(supply_ok_i),
  .adc_chan_o(adc_chan_o), .adc_start_o(adc_start_o), .adc_done_i(adc_done_i),
  .charge_pwm_out_o(charge_pwm_out_o), .current_level_pwm_out_o(current_level_pwm_out_o),
  .status_led_a_o(status_led_a_o), .status_led_b_o(status_led_b_o)
);

// file: verification/tb_lithium_charge_controller.sv
`timescale 1ns/1ns
module tb_lithium_charge_controller;
  import charge_pkg::*;
  logic sys_clk_i, rst_i, psel, penable, pwrite, pready, pslverr, bat, sup, done, start, pwm, lvl, led_a, led_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [9:0] volt, curr, temp, res;
  logic e;
  adc_chan_t chan;
  int num_errors, check_count;
  // Temps, volts, currents, limits in seconds, pwm period, led half periods
  logic [15:0] cfg [18] = '{100, 600, 650, 300, 900, 800, 780, 500, 100, 50, 80, 400, 40, 6, 40, 5, 1, 2};
  lithium_charge_controller #(.SEC_CYCLES(50), .MS_CYCLES(10)) uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .battery_present_i(bat), .supply_ok_i(sup), .adc_chan_o(chan),
    .adc_start_o(start), .adc_done_i(done), .adc_result_i(res), .charge_pwm_out_o(pwm),
    .current_level_pwm_out_o(lvl), .status_led_a_o(led_a), .status_led_b_o(led_b));
  adc_model model (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .adc_chan_i(chan), .adc_start_i(start),
    .adc_done_o(done), .adc_result_o(res), .volt_i(volt), .curr_i(curr), .temp_i(temp));
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  task report_and_stop;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    n = 0;
    // Ready, data and error read at the sampling edge, before its updates land
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      report_and_stop();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd_chk(input string name, input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, exp, q & m);
  endtask
  task wait_state(input charge_state_t st, input int bound);
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while ((q[2:0] !== st) && n < bound);
    check("state", {29'h0, st}, {29'h0, q[2:0]});
  endtask
  task quiet(input int cycles);
    logic hi;
    hi = 1'b0;
    repeat (cycles) begin
      @(posedge sys_clk_i);
      hi = hi | pwm | lvl;
    end
    check("pwm idle", 32'h0, {31'h0, hi});
  endtask
  task leds(input logic [1:0] exp);
    check("leds", {30'h0, exp}, {30'h0, led_a, led_b});
  endtask
  initial begin
    int rises;
    logic prev;
    num_errors = 0;
    check_count = 0;
    rst_i = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    bat = 1'b0;
    sup = 1'b1;
    volt = 10'd200;
    curr = 10'd0;
    temp = 10'd300;
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd_chk("status", ADDR_STATUS, 32'h7, 32'h0);
    rd_chk("ctrl", ADDR_CTRL, 32'hFFFF_FFFF, CTRL_RESET);
    apb(1'b1, 12'h000, 32'h1A5);
    rd_chk("store first", 12'h000, 32'hFFFF_FFFF, 32'hA5);
    apb(1'b1, ADDR_STORE_LAST, 32'h5A);
    rd_chk("store last", ADDR_STORE_LAST, 32'hFFFF_FFFF, 32'h5A);
    apb(1'b1, 12'h410, 32'h1);
    check("slverr", 32'h1, {31'h0, e});
    rd_chk("unmapped", 12'h410, 32'hFFFF_FFFF, 32'h0);
    check("slverr", 32'h1, {31'h0, e});
    for (int i = 0; i < 18; i++) begin
      apb(1'b1, 12'(8 * i), {24'h0, cfg[i][7:0]});
      apb(1'b1, 12'(8 * i + 4), {24'h0, cfg[i][15:8]});
    end
    bat <= 1'b1;
    sup <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h1);
    repeat (60) @(posedge sys_clk_i);
    rd_chk("no supply", ADDR_STATUS, 32'h1F, 32'h08);
    sup <= 1'b1;
    wait_state(ST_PRECHARGE, 100);
    rd_chk("meas", ADDR_MEAS_VI, 32'h03FF_03FF, 32'd200);
    volt <= 10'd500;
    wait_state(ST_CURREG, 100);
    leds(2'b10);
    rises = 0;
    prev = pwm;
    repeat (100) begin
      @(posedge sys_clk_i);
      if (pwm && !prev) rises++;
      prev = pwm;
    end
    check("pwm runs", 32'h1, {31'h0, rises >= 1 && rises <= 11});
    volt <= 10'd820;
    wait_state(ST_VOLTREG, 100);
    curr <= 10'd60;
    repeat (100) @(posedge sys_clk_i);
    rd_chk("cold taper", ADDR_STATUS, 32'h7, {29'h0, ST_VOLTREG});
    temp <= 10'd450;
    wait_state(ST_COMPLETE, 100);
    leds(2'b01);
    quiet(50);
    volt <= 10'd770;
    wait_state(ST_CURREG, 100);
    // Above recharge level so suspend holds, below target so no voltage regulation
    volt <= 10'd790;
    repeat (120) @(posedge sys_clk_i);
    rd_chk("curreg held", ADDR_STATUS, 32'h7, {29'h0, ST_CURREG});
    wait_state(ST_SUSPEND, 200);
    quiet(50);
    bat <= 1'b0;
    wait_state(ST_PENDING, 50);
    leds(2'b00);
    temp <= 10'd700;
    volt <= 10'd500;
    bat <= 1'b1;
    wait_state(ST_SUSPEND, 100);
    rst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd_chk("reset state", ADDR_STATUS, 32'h7, 32'h0);
    report_and_stop();
  end
  initial begin
    repeat (90000) @(posedge sys_clk_i);
    num_errors++;
    report_and_stop();
  end
endmodule
